// ===== src/tmc_defines.vh
// tmc_defines.vh: register indices, field positions, reset values and sizes of the timer control block.
// assumes: included by tmc_timer.v only; the bus word address equals the register index.
`ifndef TMC_DEFINES_VH
`define TMC_DEFINES_VH

// register indices (byte address is four times the index)
`define TMC_IDX_MODE 5'h00
`define TMC_IDX_IRQ_EN 5'h02
`define TMC_IDX_FLAGS 5'h06
`define TMC_IDX_FIFO_LEVEL 5'h07
`define TMC_IDX_COUNT 5'h08
`define TMC_IDX_FINAL 5'h0C
`define TMC_IDX_FIFO_DATA 5'h10

// mode register fields
`define TMC_MODE_INPUT 0
`define TMC_MODE_CLEAR 1
`define TMC_MODE_COUNT_EN 2
`define TMC_MODE_OUT_EN 3
`define TMC_MODE_SUB 4
`define TMC_MODE_EDGE_HI 7
`define TMC_MODE_EDGE_LO 6
`define TMC_MODE_WMASK 8'hDF
`define TMC_MODE_RESET 8'h02

// flag and enable fields
`define TMC_FLG_CYC_END 0
`define TMC_FLG_DATA_ACT 1
`define TMC_FLG_HALF 2
`define TMC_FLG_DMA 3
`define TMC_FLG_OVF 4
`define TMC_FLG_MASK 8'h1F

// edge select codes
`define TMC_EDGE_NONE 2'h0
`define TMC_EDGE_ANY 2'h1
`define TMC_EDGE_FALL 2'h2
`define TMC_EDGE_RISE 2'h3

// sizes
`define TMC_CW 26
`define TMC_FIFO_DEPTH 4'h8
`define TMC_FIFO_HALF 4'h4
`define TMC_REP_1 5'h01
`define TMC_REP_4 5'h04
`define TMC_REP_8 5'h08
`define TMC_REP_16 5'h10

`endif

// ===== src/tmc_timer.v
// tmc_timer.v: 26-bit timer with mode control, edge capture/count, pwm output, 8-entry fifo and flags.
// assumes: one clock ref_clk, avalon-mm slave with word addressing, timer input synchronous to ref_clk.
//
// Implementation choices: the Avalon-MM register port and the register addresses.
`include "tmc_defines.vh"

module tmc_timer #(
   parameter DMA_CAPABLE = 1
) (
   input wire ref_clk,
   input wire reset_n,
   input wire [4:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output wire [31:0] avs_readdata,
   output wire avs_waitrequest,
   input wire timer_in,
   output wire timer_out,
   output wire timer_out_oe,
   input wire dma_done,
   output wire timer_irq
);

   // phase states of the pwm period
   localparam PH_ACTIVE = 2'b01;
   localparam PH_IDLE = 2'b10;

   function edge_hit;
      input [1:0] sel;
      input prev;
      input cur;
      begin
         case (sel)
            `TMC_EDGE_ANY: edge_hit = prev ^ cur;
            `TMC_EDGE_FALL: edge_hit = prev & ~cur;
            `TMC_EDGE_RISE: edge_hit = ~prev & cur;
            default: edge_hit = 1'b0;
         endcase
      end
   endfunction

   function [4:0] repeat_count;
      input [1:0] sel;
      begin
         case (sel)
            2'h1: repeat_count = `TMC_REP_4;
            2'h2: repeat_count = `TMC_REP_8;
            2'h3: repeat_count = `TMC_REP_16;
            default: repeat_count = `TMC_REP_1;
         endcase
      end
   endfunction

   function [31:0] lane_merge;
      input [31:0] old;
      input [31:0] wd;
      input [3:0] be;
      integer i;
      begin
         lane_merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (be[i]) begin
               lane_merge[i*8 +: 8] = wd[i*8 +: 8];
            end
         end
      end
   endfunction

   function reg_sel;
      input [4:0] addr;
      input [4:0] idx;
      begin
         reg_sel = (addr == idx);
      end
   endfunction

   function [31:0] word_ext;
      input [`TMC_CW-1:0] val;
      begin
         word_ext = {6'h00, val};
      end
   endfunction

   reg [7:0] mode_q;
   reg [7:0] irq_en_q;
   reg [7:0] flags_q;
   reg [7:0] flags_d;
   reg [`TMC_CW-1:0] count_q;
   reg [`TMC_CW-1:0] count_d;
   reg [`TMC_CW-1:0] final_q;
   reg [`TMC_CW-1:0] fifo_mem [0:7];
   reg [2:0] wr_ptr_q;
   reg [2:0] rd_ptr_q;
   reg [3:0] level_q;
   reg [3:0] level_d;
   reg [`TMC_CW-1:0] duty_q;
   reg [4:0] rep_q;
   reg [1:0] phase_q;
   reg [1:0] phase_d;
   reg in_prev_q;
   reg out_q;
   reg oe_q;
   reg rd_done_q;
   reg [31:0] rdata_q;
   reg [31:0] rdata_d;

   wire input_mode = mode_q[`TMC_MODE_INPUT];
   wire count_mode = input_mode & mode_q[`TMC_MODE_SUB];
   wire capture_mode = input_mode & ~mode_q[`TMC_MODE_SUB];
   wire pwm_mode = ~input_mode & mode_q[`TMC_MODE_OUT_EN];
   wire clear_all = mode_q[`TMC_MODE_CLEAR];
   wire run = mode_q[`TMC_MODE_COUNT_EN];
   wire [1:0] edge_sel = mode_q[`TMC_MODE_EDGE_HI:`TMC_MODE_EDGE_LO];
   wire in_edge = edge_hit(edge_sel, in_prev_q, timer_in);
   wire [`TMC_CW-1:0] count_inc = count_q + 1'b1;
   wire at_final = (count_inc == final_q);
   wire [`TMC_FLG_OVF:0] irq_hits = flags_q[`TMC_FLG_OVF:0] & irq_en_q[`TMC_FLG_OVF:0];

   // fifo occupancy
   wire fifo_full = (level_q == `TMC_FIFO_DEPTH);
   wire fifo_empty = (level_q == 4'h0);
   wire fifo_last = (level_q == 4'h1);

   // bus decode
   wire wr_mode = avs_write & avs_byteenable[0] & reg_sel(avs_address, `TMC_IDX_MODE);
   wire wr_ie = avs_write & avs_byteenable[0] & reg_sel(avs_address, `TMC_IDX_IRQ_EN);
   wire wr_flags = avs_write & avs_byteenable[0] & reg_sel(avs_address, `TMC_IDX_FLAGS);
   wire wr_final = avs_write & (|avs_byteenable) & reg_sel(avs_address, `TMC_IDX_FINAL);
   wire wr_fifo = avs_write & avs_byteenable[0] & reg_sel(avs_address, `TMC_IDX_FIFO_DATA);
   wire rd_take = avs_read & ~rd_done_q;
   wire rd_fifo = rd_take & reg_sel(avs_address, `TMC_IDX_FIFO_DATA);
   wire [31:0] final_merge = lane_merge(word_ext(final_q), avs_writedata, avs_byteenable);

   assign avs_waitrequest = avs_read & ~rd_done_q;
   assign avs_readdata = rdata_q;
   assign timer_out = out_q;
   assign timer_out_oe = oe_q;
   assign timer_irq = |irq_hits;

   // datapath events
   reg push;
   reg pop;
   reg [`TMC_CW-1:0] push_val;
   reg ev_cyc;
   reg ev_act;
   reg ev_ovf;
   reg ev_half;
   reg pwm_load;
   reg [4:0] rep_d;
   reg pwm_level;

   always @* begin
      push = 1'b0;
      pop = 1'b0;
      push_val = avs_writedata[`TMC_CW-1:0];
      ev_cyc = 1'b0;
      ev_act = 1'b0;
      ev_ovf = 1'b0;
      ev_half = 1'b0;
      pwm_load = 1'b0;
      rep_d = rep_q;
      phase_d = phase_q;
      count_d = count_q;
      level_d = level_q;
      if (run) begin
         if (capture_mode) begin
            if (in_edge) begin
               push = ~fifo_full;
               push_val = count_inc;
               ev_act = 1'b1;
               count_d = {`TMC_CW{1'b0}};
            end else if (at_final) begin
               ev_cyc = 1'b1;
               count_d = {`TMC_CW{1'b0}};
            end else begin
               count_d = count_inc;
            end
         end else if (count_mode) begin
            if (in_edge) begin
               if (at_final) begin
                  ev_cyc = 1'b1;
                  count_d = {`TMC_CW{1'b0}};
               end else begin
                  count_d = count_inc;
               end
            end
         end else begin
            if (at_final) begin
               ev_cyc = 1'b1;
               count_d = {`TMC_CW{1'b0}};
               if (pwm_mode) begin
                  phase_d = PH_ACTIVE;
                  if (rep_q <= `TMC_REP_1) begin
                     rep_d = repeat_count(edge_sel);
                     pwm_load = ~fifo_empty;
                     pop = pwm_load;
                     ev_ovf = ~pwm_load | fifo_last;
                  end else begin
                     rep_d = rep_q - 1'b1;
                  end
               end
            end else begin
               count_d = count_inc;
               if (pwm_mode && phase_q == PH_ACTIVE && count_inc >= duty_q) begin
                  phase_d = PH_IDLE;
                  ev_act = 1'b1;
               end
            end
         end
      end
      if (wr_fifo && !input_mode && !fifo_full) begin
         push = 1'b1;
      end
      if (rd_fifo && input_mode && !fifo_empty) begin
         pop = 1'b1;
      end
      level_d = level_q + {3'h0, push} - {3'h0, pop};
      if (capture_mode) begin
         ev_ovf = ev_ovf | (push & (level_d == `TMC_FIFO_DEPTH));
         ev_half = (level_q >= `TMC_FIFO_HALF);
      end
      if (pwm_mode) begin
         ev_half = (level_q < `TMC_FIFO_HALF);
      end
      if (wr_final) begin
         count_d = {`TMC_CW{1'b0}};
      end
   end

   // flags: a set in the same cycle as a write-1 clear wins
   always @* begin
      flags_d = flags_q;
      if (wr_flags) begin
         flags_d = flags_q & ~avs_writedata[7:0];
      end
      flags_d[`TMC_FLG_CYC_END] = flags_d[`TMC_FLG_CYC_END] | ev_cyc;
      flags_d[`TMC_FLG_DATA_ACT] = flags_d[`TMC_FLG_DATA_ACT] | ev_act;
      flags_d[`TMC_FLG_HALF] = flags_d[`TMC_FLG_HALF] | ev_half;
      flags_d[`TMC_FLG_DMA] = flags_d[`TMC_FLG_DMA] | (dma_done & (DMA_CAPABLE != 0));
      flags_d[`TMC_FLG_OVF] = flags_d[`TMC_FLG_OVF] | ev_ovf;
      flags_d = flags_d & `TMC_FLG_MASK;
   end

   // pwm level: active while the period is in its active phase and count_q is below duty_q
   always @* begin
      pwm_level = (phase_q == PH_ACTIVE) & (count_q < duty_q);
   end

   // read mux
   always @* begin
      case (avs_address)
         `TMC_IDX_MODE: rdata_d = {24'h0, mode_q};
         `TMC_IDX_IRQ_EN: rdata_d = {24'h0, irq_en_q};
         `TMC_IDX_FLAGS: rdata_d = {24'h0, flags_q};
         `TMC_IDX_FIFO_LEVEL: rdata_d = {28'h0, level_q};
         `TMC_IDX_COUNT: rdata_d = word_ext(count_q);
         `TMC_IDX_FINAL: rdata_d = word_ext(final_q);
         `TMC_IDX_FIFO_DATA: rdata_d = word_ext(fifo_mem[rd_ptr_q]);
         default: rdata_d = 32'h0;
      endcase
   end

   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_q <= `TMC_MODE_RESET;
         irq_en_q <= 8'h00;
         flags_q <= 8'h00;
         final_q <= {`TMC_CW{1'b0}};
         rd_done_q <= 1'b0;
         rdata_q <= 32'h0;
      end else begin
         rd_done_q <= rd_take;
         if (rd_take) begin
            rdata_q <= rdata_d;
         end
         if (wr_mode) begin
            mode_q <= avs_writedata[7:0] & `TMC_MODE_WMASK;
         end
         if (wr_ie) begin
            irq_en_q <= avs_writedata[7:0] & `TMC_FLG_MASK;
         end
         if (wr_final) begin
            final_q <= final_merge[`TMC_CW-1:0];
         end
         flags_q <= clear_all ? 8'h00 : flags_d;
      end
   end

   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         count_q <= {`TMC_CW{1'b0}};
         wr_ptr_q <= 3'h0;
         rd_ptr_q <= 3'h0;
         level_q <= 4'h0;
         duty_q <= {`TMC_CW{1'b0}};
         rep_q <= `TMC_REP_1;
         phase_q <= PH_IDLE;
         in_prev_q <= 1'b0;
      end else begin
         in_prev_q <= timer_in;
         if (clear_all) begin
            count_q <= {`TMC_CW{1'b0}};
            wr_ptr_q <= 3'h0;
            rd_ptr_q <= 3'h0;
            level_q <= 4'h0;
            rep_q <= `TMC_REP_1;
            phase_q <= PH_IDLE;
         end else begin
            count_q <= count_d;
            level_q <= level_d;
            rep_q <= rep_d;
            phase_q <= phase_d;
            if (push) begin
               wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
               rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if (pwm_load) begin
               duty_q <= fifo_mem[rd_ptr_q];
            end
         end
      end
   end

   // fifo storage, data only, no reset needed
   always @(posedge ref_clk) begin
      if (push && !clear_all) begin
         fifo_mem[wr_ptr_q] <= push_val;
      end
   end

   // output pin
   wire pwm_drive = pwm_mode & pwm_level;

   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         out_q <= 1'b0;
         oe_q <= 1'b0;
      end else begin
         oe_q <= mode_q[`TMC_MODE_OUT_EN];
         if (mode_q[`TMC_MODE_OUT_EN]) begin
            out_q <= pwm_drive ^ (pwm_mode & mode_q[`TMC_MODE_SUB]);
         end else begin
            out_q <= 1'b0;
         end
      end
   end

endmodule // tmc_timer

// ===== testbench/tb_tmc.sv
// tb_tmc.sv: register-level tests of the timer control block with the pin partner.
// assumes: tmc_timer, tmc_pin_model and tmc_checker compiled before.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk, reset_n, avs_read, avs_write, go, idle_lv, dma_done;
   logic avs_waitrequest, timer_in, timer_out, timer_out_oe, timer_irq, busy;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [15:0] act, a0;
   logic [7:0] pn, pg;
   logic [7:0] cmode [5] = '{8'h15, 8'h55, 8'h95, 8'hD5, 8'hD1};
   logic [7:0] cexp [5] = '{8'h00, 8'h06, 8'h03, 8'h03, 8'h00};
   int err_total = 0, samples_checked = 0, k;
   tmc_timer u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .timer_in(timer_in), .timer_out(timer_out),
      .timer_out_oe(timer_out_oe), .dma_done(dma_done), .timer_irq(timer_irq));
   tmc_pin_model u_pin (.ref_clk(ref_clk), .reset_n(reset_n), .go(go), .n(pn), .gap(pg), .idle_lv(idle_lv),
      .timer_out(timer_out), .timer_out_oe(timer_out_oe), .timer_in(timer_in), .busy(busy), .act(act));
   always #10 ref_clk = ~ref_clk;
   task automatic tally_and_finish;
      if (err_total == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic fail_hang;
      err_total++;
      tally_and_finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic xf(input logic r, input logic [4:0] a, input logic [31:0] d);
      int i;
      i = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= r;
      avs_write <= !r;
      @(posedge ref_clk);
      while (avs_waitrequest && i < 40) begin
         @(posedge ref_clk);
         i++;
      end
      if (i == 40)
         fail_hang;
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      xf(1'b0, a, d);
   endtask
   task automatic rc(input logic [4:0] a, input logic [31:0] e);
      xf(1'b1, a, 32'h0);
      chk(q, e);
   endtask
   task automatic pl(input logic [7:0] n, input logic [7:0] g);
      int i;
      i = 0;
      pn <= n;
      pg <= g;
      go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      @(negedge ref_clk);
      while (busy && i < 3000) begin
         @(negedge ref_clk);
         i++;
      end
      if (i == 3000)
         fail_hang;
      repeat (3) @(posedge ref_clk);
   endtask
   initial begin
      ref_clk = 1'b0;
      reset_n = 1'b0;
      {avs_read, avs_write, go, idle_lv, dma_done} = 5'h0;
      avs_address = 5'h0;
      avs_writedata = 32'h0;
      pn = 8'h0;
      pg = 8'h0;
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      rc(5'h00, 32'h02);
      rc(5'h02, 32'h00);
      rc(5'h06, 32'h00);
      rc(5'h07, 32'h00);
      wr(5'h02, 32'hFF);
      rc(5'h02, 32'h1F);
      wr(5'h00, 32'hFF);
      rc(5'h00, 32'hDF);
      wr(5'h00, 32'h00);
      dma_done <= 1'b1;
      @(posedge ref_clk);
      dma_done <= 1'b0;
      @(posedge ref_clk);
      rc(5'h06, 32'h08);
      chk({31'h0, timer_irq}, 32'h1);
      wr(5'h06, 32'h00);
      rc(5'h06, 32'h08);
      wr(5'h06, 32'h08);
      rc(5'h06, 32'h00);
      wr(5'h02, 32'h00);
      for (k = 0; k < 5; k++) begin
         wr(5'h00, {24'h0, cmode[k]});
         wr(5'h0C, 32'h64);
         pl(8'h3, 8'h4);
         rc(5'h08, {24'h0, cexp[k]});
      end
      wr(5'h00, 32'hD5);
      wr(5'h0C, 32'h5);
      pl(8'h7, 8'h4);
      rc(5'h08, 32'h02);
      rc(5'h06, 32'h01);
      wr(5'h02, 32'h01);
      chk({31'h0, timer_irq}, 32'h1);
      wr(5'h06, 32'h1E);
      rc(5'h06, 32'h01);
      wr(5'h06, 32'h01);
      chk({31'h0, timer_irq}, 32'h0);
      wr(5'h02, 32'h00);
      wr(5'h0C, 32'h3E8);
      wr(5'h00, 32'hC5);
      pl(8'h9, 8'h5);
      rc(5'h07, 32'h08);
      rc(5'h06, 32'h16);
      xf(1'b1, 5'h10, 32'h0);
      rc(5'h10, 32'hA);
      rc(5'h07, 32'h06);
      wr(5'h00, 32'h02);
      rc(5'h07, 32'h00);
      rc(5'h08, 32'h00);
      rc(5'h06, 32'h00);
      wr(5'h00, 32'h08);
      for (k = 0; k < 9; k++)
         wr(5'h10, 32'h3);
      rc(5'h07, 32'h08);
      wr(5'h0C, 32'hA);
      a0 = act;
      wr(5'h00, 32'h0C);
      repeat (88) @(posedge ref_clk);
      chk({16'h0, act - a0}, 32'h18);
      rc(5'h06, 32'h17);
      wr(5'h00, 32'h02);
      idle_lv <= 1'b1;
      wr(5'h00, 32'h58);
      wr(5'h10, 32'h3);
      wr(5'h10, 32'h3);
      a0 = act;
      wr(5'h00, 32'h5C);
      repeat (88) @(posedge ref_clk);
      chk({16'h0, act - a0}, 32'h18);
      chk({31'h0, timer_out}, 32'h1);
      wr(5'h00, 32'h50);
      @(negedge ref_clk);
      chk({30'h0, timer_out_oe, timer_out}, 32'h0);
      tally_and_finish;
   end
endmodule // testbench

// ===== testbench/tmc_checker.sv
// tmc_checker.sv: port assertions for the timer control block.
// assumes: bound into tmc_timer, one clock ref_clk, reset_n active low.
module tmc_checker (
   input wire ref_clk,
   input wire reset_n,
   input wire [4:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [31:0] avs_readdata,
   input wire avs_waitrequest,
   input wire timer_out,
   input wire timer_out_oe,
   input wire timer_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);
   wire mode_wr = avs_write && avs_address == 5'h00;
   wire rd_end = avs_read && !avs_waitrequest;
   write_nowait_a: assert property (avs_write |-> !avs_waitrequest)
      else $error("write stalled");
   read_one_wait_a: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
      else $error("read wait too long");
   oe_follow_a: assert property (mode_wr |=> ##1 timer_out_oe == $past(avs_writedata[3], 2))
      else $error("oe not mode bit");
   out_quiet_a: assert property (!timer_out_oe |-> !timer_out)
      else $error("output moves while disabled");
   clear_irq_a: assert property (mode_wr && avs_writedata[1] |-> ##2 !timer_irq [*2])
      else $error("irq during force clear");
   irq_mask_a: assert property (avs_write && avs_address == 5'h02 && avs_writedata[4:0] == 5'h00 |=> !timer_irq)
      else $error("irq with enables off");
   level_max_a: assert property (rd_end && avs_address == 5'h07 |-> avs_readdata <= 32'h8)
      else $error("fifo level above eight");
   enable_rsvd_a: assert property (rd_end && avs_address == 5'h02 |-> avs_readdata[7:5] == 3'h0)
      else $error("reserved enable bits set");
   cover property (mode_wr && avs_writedata[0]);
   cover property (timer_irq);
   cover property (timer_out_oe && timer_out);
endmodule // tmc_checker

bind tmc_timer tmc_checker u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .timer_out(timer_out), .timer_out_oe(timer_out_oe), .timer_irq(timer_irq));

// ===== testbench/tmc_pin_model.sv
// tmc_pin_model.sv: pin partner; pulses the timer input, counts active output cycles.
// assumes: timer input sampled on ref_clk; go is one cycle with n and gap held.
module tmc_pin_model (
   input wire ref_clk,
   input wire reset_n,
   input wire go,
   input wire [7:0] n,
   input wire [7:0] gap,
   input wire idle_lv,
   input wire timer_out,
   input wire timer_out_oe,
   output logic timer_in,
   output wire busy,
   output logic [15:0] act
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [8:0] left_q;
   logic [7:0] tick_q;
   assign busy = left_q != 9'h0;
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         timer_in <= 1'b0;
         left_q <= 9'h0;
         tick_q <= 8'h0;
         act <= 16'h0;
      end else begin
         if (timer_out_oe && timer_out != idle_lv)
            act <= act + 16'h1;
         if (go) begin
            left_q <= {n, 1'b0};
            tick_q <= gap;
         end else if (busy && tick_q == 8'h1) begin
            timer_in <= ~timer_in;
            left_q <= left_q - 9'h1;
            tick_q <= gap;
         end else if (busy)
            tick_q <= tick_q - 8'h1;
      end
   end
endmodule // tmc_pin_model
